// File: bench/srm_board_model.sv
// Board-side model: fundamental reset source and strap resistors
// Assumes: bench calls its tasks, one core clock
`timescale 1ns/1ns
module srm_board_model (
  input  wire logic clk_i,
  output logic       fund_n_o,
  output logic       cc_dn_o,
  output logic       cc_up_o,
  output logic       slow_o,
  output logic       halt_o,
  output logic [3:0] mode_o
);
  initial begin
    fund_n_o = 1'b0;
    {cc_dn_o, cc_up_o, slow_o, halt_o, mode_o} = 8'h00;
  end
  // Straps {down, up, slow, halt, mode} set while reset is low
  task automatic hold_reset(input logic [7:0] s);
    @(posedge clk_i);
    fund_n_o <= 1'b0;
    {cc_dn_o, cc_up_o, slow_o, halt_o, mode_o} <= s;
    repeat (6) @(posedge clk_i);
  endtask : hold_reset
  // Straps stay untouched until the next reset
  task automatic release_reset();
    @(posedge clk_i);
    fund_n_o <= 1'b1;
  endtask : release_reset
endmodule : srm_board_model

// File: bench/switch_reset_mode_straps_bench.sv
// Testbench: reset, strap capture, halt release and GPIO reset pins
// Assumes: srm_top with AXI4-Lite register access, 100 MHz clock
`timescale 1ns/1ns
module switch_reset_mode_straps_bench;
  import srm_pkg::*;
  logic        clk_i, reset_n_i, fund_n, cc_dn, cc_up, slow, halt;
  logic [3:0]  mode;
  logic [7:0]  aw, ar;
  logic [31:0] wd, rd, q;
  logic        awv, awr, wv, wr, bv, bre, arv, arr, rv, rre;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  ws;
  logic        core_n, fund_rst, ccd, ccu, eep, rsv, g9, g9e, g10, g10e;
  logic [15:0] half;
  int          n_errors, checked;

  srm_board_model srm_board_model_inst (.clk_i(clk_i), .fund_n_o(fund_n),
    .cc_dn_o(cc_dn), .cc_up_o(cc_up), .slow_o(slow), .halt_o(halt),
    .mode_o(mode));

  srm_top srm_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .fundamental_reset_n_i(fund_n), .common_clock_down_strap_i(cc_dn),
    .common_clock_up_strap_i(cc_up), .master_bus_slow_strap_i(slow),
    .reset_halt_i(halt), .switch_mode_strap_i(mode),
    .s_axil_awaddr_i(aw), .s_axil_awvalid_i(awv), .s_axil_awready_o(awr),
    .s_axil_wdata_i(wd), .s_axil_wstrb_i(ws), .s_axil_wvalid_i(wv),
    .s_axil_wready_o(wr), .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bv),
    .s_axil_bready_i(bre), .s_axil_araddr_i(ar), .s_axil_arvalid_i(arv),
    .s_axil_arready_o(arr), .s_axil_rdata_o(rd), .s_axil_rresp_o(rresp),
    .s_axil_rvalid_o(rv), .s_axil_rready_i(rre), .core_reset_n_o(core_n),
    .pcie_fund_reset_o(fund_rst), .common_clock_down_o(ccd),
    .common_clock_up_o(ccu), .master_bus_half_period_o(half),
    .mode_eeprom_init_o(eep), .mode_reserved_o(rsv), .gpio9_o(g9),
    .gpio9_oe_o(g9e), .gpio10_o(g10), .gpio10_oe_o(g10e));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic guard(input int n);
    if (n >= 300) begin
      n_errors++;
      final_report();
    end
  endtask : guard

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk_i);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 300);
    resp = bresp;
    bre <= 1'b0;
    guard(n);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er,
                        output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arv && arr) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 300);
    d = rd;
    rre <= 1'b0;
    guard(n);
    chk(rresp, er);
  endtask : rd_reg

  // Wait for core_reset_n_o (sel 0) or pcie_fund_reset_o (sel 1)
  task automatic wfor(input logic sel, input logic v);
    int n;
    n = 0;
    while (((sel ? fund_rst : core_n) !== v) && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    guard(n);
  endtask : wfor

  task automatic t_reset();
    chk(core_n, 1'b0);
    chk(fund_rst, 1'b1);
    rd_reg(OFF_GPIO, RESP_OKAY, q);
    chk(q, 32'(GPIO_RESET));
    rd_reg(8'h0c, RESP_SLVERR, q);
    chk(q, 32'h0);
    wr_reg(8'h0c, 32'h1, r);
    chk(r, RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset

  task automatic t_halt();
    srm_board_model_inst.hold_reset(8'hb1);
    srm_board_model_inst.release_reset();
    wfor(1'b1, 1'b0);
    repeat (40) @(posedge clk_i);
    chk(core_n, 1'b0);
    chk(ccd, 1'b1);
    chk(ccu, 1'b0);
    chk(half, BUS_SLOW_DIV);
    chk(eep, 1'b1);
    chk(rsv, 1'b0);
    rd_reg(OFF_CONTROL, RESP_OKAY, q);
    chk(q, 32'h1);
    rd_reg(OFF_STATUS, RESP_OKAY, q);
    chk(q, 32'h51);
    wr_reg(OFF_GPIO, 32'h33, r);
    chk(r, RESP_OKAY);
    ws <= 4'he;
    wr_reg(OFF_CONTROL, 32'h0, r);
    ws <= 4'hf;
    wr_reg(OFF_CONTROL, 32'h1, r);
    repeat (5) @(posedge clk_i);
    chk(core_n, 1'b0);
    chk({g9, g10}, 2'h0);
    wr_reg(OFF_CONTROL, 32'h0, r);
    wfor(1'b0, 1'b1);
    rd_reg(OFF_STATUS, RESP_OKAY, q);
    chk(q, 32'hd1);
    chk({g9, g9e, g10, g10e}, 4'hf);
    wr_reg(OFF_GPIO, 32'h08, r);
    rd_reg(OFF_GPIO, RESP_OKAY, q);
    chk(q, 32'h08);
    chk({g9, g10}, 2'h1);
    $display("test halt done");
  endtask : t_halt

  task automatic t_modes();
    logic [4:0] m;
    for (m = 5'h0; m < 5'h10; m++) begin
      srm_board_model_inst.hold_reset({4'h4, m[3:0]});
      wfor(1'b1, 1'b1);
      chk(core_n, 1'b0);
      srm_board_model_inst.release_reset();
      wfor(1'b0, 1'b1);
      wr_reg(OFF_STATUS, 32'h40, r);
      chk({ccd, ccu}, 2'h1);
      chk(half, BUS_FAST_DIV);
      chk({eep, rsv}, {m == 5'h1, m > 5'h1});
      rd_reg(OFF_STATUS, RESP_OKAY, q);
      chk(q, {23'h0, m > 5'h1, 4'ha, m[3:0]});
    end
    $display("test modes done");
  endtask : t_modes

  initial begin
    n_errors = 0;
    checked = 0;
    reset_n_i = 1'b0;
    {aw, ar, wd, awv, wv, bre, arv, rre} = '0;
    ws = 4'hf;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_halt();
    t_modes();
    final_report();
  end
endmodule : switch_reset_mode_straps_bench

// File: verilog/srm_axil.sv
// Module: AXI4-Lite slave for the control, status and GPIO registers
// Assumes: single outstanding read and write, 32-bit data
`timescale 1ns/1ns
module srm_axil (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  srm_reg_if.slave         regs
);
  import srm_pkg::*;
  logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next;
  logic        rv_reg, rv_next, clr_reg, clr_next;
  logic [7:0]  awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;
  logic [5:0]  gp_reg, gp_next;
  logic        awrdy_reg, awrdy_next, wrdy_reg, wrdy_next;
  logic        ardy_reg, ardy_next;
  always_comb begin
    aw_next = aw_reg; w_next = w_reg; awa_next = awa_reg;
    wd_next = wd_reg; ws_next = ws_reg; bv_next = bv_reg;
    br_next = br_reg; gp_next = gp_reg; clr_next = 1'b0;
    rv_next = rv_reg; rd_next = rd_reg; rr_next = rr_reg;
    if (awvalid_i && !aw_reg && !bv_reg) begin
      aw_next = 1'b1; awa_next = awaddr_i;
    end
    if (wvalid_i && !w_reg && !bv_reg) begin
      w_next = 1'b1; wd_next = wdata_i; ws_next = wstrb_i;
    end
    if (aw_reg && w_reg) begin
      aw_next = 1'b0; w_next = 1'b0; bv_next = 1'b1;
      br_next = RESP_OKAY;
      if (awa_reg[7:2] == OFF_CONTROL[7:2]) begin
        // Only a written zero to the halt bit releases the device
        if (ws_reg[0] && !wd_reg[CTL_HALT_BIT]) clr_next = 1'b1;
      end else if (awa_reg[7:2] == OFF_GPIO[7:2]) begin
        if (ws_reg[0]) gp_next = wd_reg[5:0];
      end else if (awa_reg[7:2] == OFF_STATUS[7:2]) begin
        br_next = RESP_OKAY;
      end else begin
        br_next = RESP_SLVERR;
      end
    end
    if (bv_reg && bready_i) bv_next = 1'b0;
    if (rv_reg && rready_i) rv_next = 1'b0;
    else if (arvalid_i && !rv_reg) begin
      rv_next = 1'b1; rr_next = RESP_OKAY; rd_next = 32'h0;
      if (araddr_i[7:2] == OFF_CONTROL[7:2]) begin
        rd_next[CTL_HALT_BIT] = regs.halt_bit;
      end else if (araddr_i[7:2] == OFF_STATUS[7:2]) begin
        rd_next = regs.status;
      end else if (araddr_i[7:2] == OFF_GPIO[7:2]) begin
        rd_next = {26'h0, gp_reg};
      end else begin
        rr_next = RESP_SLVERR;
      end
    end
    // Ready flags are registered so the pins come from flip-flops
    awrdy_next = !aw_next && !bv_next;
    wrdy_next  = !w_next && !bv_next;
    ardy_next  = !rv_next;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_reg <= 1'b0; w_reg <= 1'b0; bv_reg <= 1'b0; rv_reg <= 1'b0;
      awa_reg <= 8'h0; wd_reg <= 32'h0; ws_reg <= 4'h0;
      br_reg <= 2'h0; rr_reg <= 2'h0; rd_reg <= 32'h0;
      gp_reg <= GPIO_RESET; clr_reg <= 1'b0;
      awrdy_reg <= 1'b1;
      wrdy_reg <= 1'b1;
      ardy_reg <= 1'b1;
    end else begin
      aw_reg <= aw_next; w_reg <= w_next; bv_reg <= bv_next;
      rv_reg <= rv_next; awa_reg <= awa_next; wd_reg <= wd_next;
      ws_reg <= ws_next; br_reg <= br_next; rr_reg <= rr_next;
      rd_reg <= rd_next; gp_reg <= gp_next; clr_reg <= clr_next;
      awrdy_reg <= awrdy_next;
      wrdy_reg <= wrdy_next;
      ardy_reg <= ardy_next;
    end
  end
  assign awready_o = awrdy_reg;
  assign wready_o  = wrdy_reg;
  assign bvalid_o  = bv_reg;
  assign bresp_o   = br_reg;
  assign arready_o = ardy_reg;
  assign rvalid_o  = rv_reg;
  assign rdata_o   = rd_reg;
  assign rresp_o   = rr_reg;
  assign regs.halt_clear = clr_reg;
  assign regs.gpio_ctl   = gp_reg;
endmodule : srm_axil

// File: verilog/srm_pkg.sv
// Package: constants for the switch reset and mode strap block
// Assumes: 100 MHz core clock, AXI4-Lite register access
package srm_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned BUS_FAST_HZ     = 400_000;
  localparam int unsigned BUS_SLOW_HZ     = 100_000;
  localparam logic [15:0] BUS_FAST_DIV    =
    16'(CLK_HZ / (2 * BUS_FAST_HZ));
  localparam logic [15:0] BUS_SLOW_DIV    =
    16'(CLK_HZ / (2 * BUS_SLOW_HZ));
  localparam logic [7:0]  RST_SEQ_CYCLES  = 8'h10;
  localparam logic [3:0]  MODE_NORMAL     = 4'h0;
  localparam logic [3:0]  MODE_EEPROM     = 4'h1;
  localparam logic [7:0]  OFF_CONTROL     = 8'h00;
  localparam logic [7:0]  OFF_STATUS      = 8'h04;
  localparam logic [7:0]  OFF_GPIO        = 8'h08;
  localparam int unsigned CTL_HALT_BIT    = 0;
  localparam int unsigned ST_MODE_LSB     = 0;
  localparam int unsigned ST_CCDN_BIT     = 4;
  localparam int unsigned ST_CCUP_BIT     = 5;
  localparam int unsigned ST_SLOW_BIT     = 6;
  localparam int unsigned ST_RUN_BIT      = 7;
  localparam int unsigned ST_RSVD_BIT     = 8;
  localparam int unsigned GP_ALT9_BIT     = 0;
  localparam int unsigned GP_ALT10_BIT    = 1;
  localparam int unsigned GP_OUT9_BIT     = 2;
  localparam int unsigned GP_OUT10_BIT    = 3;
  localparam int unsigned GP_P3RST_BIT    = 4;
  localparam int unsigned GP_P5RST_BIT    = 5;
  localparam logic [5:0]  GPIO_RESET      = 6'h03;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  typedef enum logic [1:0] {ST_HELD, ST_SEQ, ST_HALTED, ST_RUN} srm_state_t;
endpackage : srm_pkg

// File: verilog/srm_reg_if.sv
// Interface: register values passed between the bus slave and the core
// Assumes: one clock domain
`timescale 1ns/1ns
interface srm_reg_if;
  logic        halt_clear;
  logic [5:0]  gpio_ctl;
  logic [31:0] status;
  logic        halt_bit;
  modport slave (output halt_clear, output gpio_ctl,
                 input status, input halt_bit);
  modport core  (input halt_clear, input gpio_ctl,
                 output status, output halt_bit);
endinterface : srm_reg_if

// File: verilog/srm_sync.sv
// Module: three-stage synchroniser with agreement on the last two
// Assumes: asynchronous input, one clock
`timescale 1ns/1ns
module srm_sync #(parameter int W = 1) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg, q_next;
  always_comb begin
    q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end
  assign q_o = q_reg;
endmodule : srm_sync

// File: verilog/srm_top.sv
// What this block does
// - Down common-clock strap marks the downstream reference clock shared
// - Up common-clock strap marks the upstream reference clock shared
// - Slow strap runs master bus at 100 kHz, else 400 kHz; fixed
// - Fundamental reset low resets the sequencer and the halt bit, not the other registers or latched straps, and starts fundamental reset
// - Halt strap during reset: run sequence, then hold in reset state
// - Registers stay readable and writable while halted
// - Only clearing the halt bit releases the halted device
// - Mode strap: 0 normal, 1 EEPROM init, 2 to F reserved
// - GPIO 9 alternate function drives port three reset
// - GPIO 10 alternate function drives port five reset
//
// Top: reset sequencer, strap capture and reset output pins
// Assumes: straps and fundamental reset are asynchronous board pins
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module srm_top (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        fundamental_reset_n_i,
  input  wire logic        common_clock_down_strap_i,
  input  wire logic        common_clock_up_strap_i,
  input  wire logic        master_bus_slow_strap_i,
  input  wire logic        reset_halt_i,
  input  wire logic [3:0]  switch_mode_strap_i,
  input  wire logic [7:0]  s_axil_awaddr_i,
  input  wire logic        s_axil_awvalid_i,
  output logic             s_axil_awready_o,
  input  wire logic [31:0] s_axil_wdata_i,
  input  wire logic [3:0]  s_axil_wstrb_i,
  input  wire logic        s_axil_wvalid_i,
  output logic             s_axil_wready_o,
  output logic [1:0]       s_axil_bresp_o,
  output logic             s_axil_bvalid_o,
  input  wire logic        s_axil_bready_i,
  input  wire logic [7:0]  s_axil_araddr_i,
  input  wire logic        s_axil_arvalid_i,
  output logic             s_axil_arready_o,
  output logic [31:0]      s_axil_rdata_o,
  output logic [1:0]       s_axil_rresp_o,
  output logic             s_axil_rvalid_o,
  input  wire logic        s_axil_rready_i,
  output logic             core_reset_n_o,
  output logic             pcie_fund_reset_o,
  output logic             common_clock_down_o,
  output logic             common_clock_up_o,
  output logic [15:0]      master_bus_half_period_o,
  output logic             mode_eeprom_init_o,
  output logic             mode_reserved_o,
  output logic             gpio9_o,
  output logic             gpio9_oe_o,
  output logic             gpio10_o,
  output logic             gpio10_oe_o
);
  import srm_pkg::*;

  srm_reg_if regs ();

  logic       fr_n_s;
  logic [7:0] straps_s;
  srm_sync #(.W(1)) u_sync_rst (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (fundamental_reset_n_i),
    .q_o       (fr_n_s)
  );
  srm_sync #(.W(8)) u_sync_strap (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({reset_halt_i, master_bus_slow_strap_i,
                 common_clock_up_strap_i, common_clock_down_strap_i,
                 switch_mode_strap_i}),
    .q_o       (straps_s)
  );

  srm_axil u_axil (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .awaddr_i  (s_axil_awaddr_i),
    .awvalid_i (s_axil_awvalid_i),
    .awready_o (s_axil_awready_o),
    .wdata_i   (s_axil_wdata_i),
    .wstrb_i   (s_axil_wstrb_i),
    .wvalid_i  (s_axil_wvalid_i),
    .wready_o  (s_axil_wready_o),
    .bresp_o   (s_axil_bresp_o),
    .bvalid_o  (s_axil_bvalid_o),
    .bready_i  (s_axil_bready_i),
    .araddr_i  (s_axil_araddr_i),
    .arvalid_i (s_axil_arvalid_i),
    .arready_o (s_axil_arready_o),
    .rdata_o   (s_axil_rdata_o),
    .rresp_o   (s_axil_rresp_o),
    .rvalid_o  (s_axil_rvalid_o),
    .rready_i  (s_axil_rready_i),
    .regs      (regs)
  );

  function automatic logic [15:0] bus_div(input logic slow);
    bus_div = slow ? BUS_SLOW_DIV : BUS_FAST_DIV;
  endfunction : bus_div

  srm_state_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [3:0] mode_reg, mode_next;
  logic       ccd_reg, ccd_next, ccu_reg, ccu_next;
  logic       slow_reg, slow_next, halt_reg, halt_next;
  logic       crst_reg, crst_next, frst_reg, frst_next;
  logic [15:0] div_reg, div_next;
  logic       eep_reg, eep_next, rsv_reg, rsv_next;
  logic       g9_reg, g9_next, g9oe_reg, g9oe_next;
  logic       g10_reg, g10_next, g10oe_reg, g10oe_next;
  logic [5:0] gp;

  assign gp = regs.gpio_ctl;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    ccd_next = ccd_reg;
    ccu_next = ccu_reg;
    slow_next = slow_reg;
    halt_next = halt_reg;
    if (!fr_n_s) begin
      st_next = ST_HELD;
      cnt_next = 8'h0;
      halt_next = 1'b0;
    end else begin
      case (st_reg)
        ST_HELD: begin
          // Latch straps at release of fundamental reset
          mode_next = straps_s[3:0];
          ccd_next  = straps_s[4];
          ccu_next  = straps_s[5];
          slow_next = straps_s[6];
          halt_next = straps_s[7];
          st_next   = ST_SEQ;
        end
        ST_SEQ: begin
          cnt_next = cnt_reg + 8'h1;
          if (cnt_reg == RST_SEQ_CYCLES - 8'h1) begin
            st_next = halt_reg ? ST_HALTED : ST_RUN;
          end
        end
        ST_HALTED: begin
          if (regs.halt_clear) st_next = ST_RUN;
        end
        default: st_next = ST_RUN;
      endcase
      // Strap latch wins over a clear landing in the same cycle
      if (regs.halt_clear && st_reg != ST_HELD) halt_next = 1'b0;
    end
    crst_next = (st_next == ST_RUN);
    frst_next = (st_next == ST_HELD);
    div_next  = bus_div(slow_next);
    eep_next  = (mode_next == MODE_EEPROM);
    rsv_next  = (mode_next != MODE_NORMAL) && (mode_next != MODE_EEPROM);
    g9oe_next  = 1'b1;
    g10oe_next = 1'b1;
    // Alternate function: port reset low until core runs and software lets go
    g9_next  = gp[GP_ALT9_BIT] ?
               (crst_next && gp[GP_P3RST_BIT]) : gp[GP_OUT9_BIT];
    g10_next = gp[GP_ALT10_BIT] ?
               (crst_next && gp[GP_P5RST_BIT]) : gp[GP_OUT10_BIT];
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= ST_HELD;
      cnt_reg <= 8'h0;
      mode_reg <= MODE_NORMAL;
      ccd_reg <= 1'b0;
      ccu_reg <= 1'b0;
      slow_reg <= 1'b0;
      halt_reg <= 1'b0;
      crst_reg <= 1'b0;
      frst_reg <= 1'b1;
      div_reg <= BUS_FAST_DIV;
      eep_reg <= 1'b0;
      rsv_reg <= 1'b0;
      g9_reg <= 1'b0;
      g9oe_reg <= 1'b1;
      g10_reg <= 1'b0;
      g10oe_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
      ccd_reg <= ccd_next;
      ccu_reg <= ccu_next;
      slow_reg <= slow_next;
      halt_reg <= halt_next;
      crst_reg <= crst_next;
      frst_reg <= frst_next;
      div_reg <= div_next;
      eep_reg <= eep_next;
      rsv_reg <= rsv_next;
      g9_reg <= g9_next;
      g9oe_reg <= g9oe_next;
      g10_reg <= g10_next;
      g10oe_reg <= g10oe_next;
    end
  end

  // Cycles spent in the reset sequence, for the length check
  logic [7:0] seq_seen_reg, seq_seen_next;
  always_comb begin
    if (st_reg == ST_SEQ) begin
      seq_seen_next = seq_seen_reg + 8'h1;
    end else begin
      seq_seen_next = 8'h0;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_seen_reg <= 8'h0;
    end else begin
      seq_seen_reg <= seq_seen_next;
    end
  end

  assign regs.halt_bit = halt_reg;
  assign regs.status = {23'h0, rsv_reg, crst_reg, slow_reg, ccu_reg,
                        ccd_reg, mode_reg};
  assign core_reset_n_o          = crst_reg;
  assign pcie_fund_reset_o       = frst_reg;
  assign common_clock_down_o     = ccd_reg;
  assign common_clock_up_o       = ccu_reg;
  assign master_bus_half_period_o = div_reg;
  assign mode_eeprom_init_o      = eep_reg;
  assign mode_reserved_o         = rsv_reg;
  assign gpio9_o                 = g9_reg;
  assign gpio9_oe_o              = g9oe_reg;
  assign gpio10_o                = g10_reg;
  assign gpio10_oe_o             = g10oe_reg;

  AST_HELD_IN_RESET: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !fr_n_s |=> !crst_reg && frst_reg)
    else $error("core not held while fundamental reset low");
  AST_FUND_NOT_CORE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    pcie_fund_reset_o |-> !core_reset_n_o)
    else $error("core running during fundamental reset");
  AST_HALT_STAYS: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_reg == ST_HALTED && fr_n_s && !regs.halt_clear |=> !crst_reg)
    else $error("halted device left reset without clear");
  AST_CLEAR_RELEASES: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_reg == ST_HALTED && fr_n_s && regs.halt_clear |=> crst_reg)
    else $error("halt clear did not release device");
  AST_CLEAR_DROPS_HALT: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    regs.halt_clear && st_reg != ST_HELD && fr_n_s |=> !halt_reg)
    else $error("halt bit survived a clear");
  AST_RUN_NO_HALT: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_reg == ST_RUN |-> !halt_reg)
    else $error("device running with halt bit set");
  AST_SPEED: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    div_reg == (slow_reg ? BUS_SLOW_DIV : BUS_FAST_DIV))
    else $error("bus speed does not follow slow strap");
  AST_MODE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    eep_reg == (mode_reg == MODE_EEPROM) && !(eep_reg && rsv_reg))
    else $error("mode decode wrong");
  AST_LATCH: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_reg == ST_HELD && fr_n_s |=> mode_reg == $past(straps_s[3:0])
    && halt_reg == $past(straps_s[7]))
    else $error("straps not latched at release");
  AST_STRAPS_HOLD: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_reg != ST_HELD |=> $stable(mode_reg) && $stable(slow_reg)
    && $stable(ccd_reg) && $stable(ccu_reg))
    else $error("latched straps changed outside reset");
  AST_SEQ_ENTRY: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_reg == ST_HELD && fr_n_s |=> st_reg == ST_SEQ && cnt_reg == 8'h0)
    else $error("reset sequence did not start at release");
  AST_SEQ_LEN: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $fell(st_reg == ST_SEQ) && $past(fr_n_s)
    |-> $past(seq_seen_reg) == RST_SEQ_CYCLES - 8'h1)
    else $error("reset sequence length wrong");
  AST_SEQ_MAX: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_reg == ST_SEQ |-> seq_seen_reg < RST_SEQ_CYCLES)
    else $error("reset sequence overran");
  AST_P3: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    gp[GP_ALT9_BIT] && !crst_next |=> !gpio9_o)
    else $error("port three reset not asserted");
  AST_P3_RELEASE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    gp[GP_ALT9_BIT] && gp[GP_P3RST_BIT] |=> gpio9_o == core_reset_n_o)
    else $error("port three reset does not follow core");
  AST_GPIO9_DIRECT: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !gp[GP_ALT9_BIT] |=> gpio9_o == $past(gp[GP_OUT9_BIT]))
    else $error("pin nine does not follow its output bit");
  AST_P5: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    gp[GP_ALT10_BIT] && !crst_next |=> !gpio10_o)
    else $error("port five reset not asserted");
  AST_P5_RELEASE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    gp[GP_ALT10_BIT] && gp[GP_P5RST_BIT] |=> gpio10_o == core_reset_n_o)
    else $error("port five reset does not follow core");
  AST_GPIO10_DIRECT: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !gp[GP_ALT10_BIT] |=> gpio10_o == $past(gp[GP_OUT10_BIT]))
    else $error("pin ten does not follow its output bit");
  AST_CC: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_reg == ST_HELD && fr_n_s |=> common_clock_down_o == $past(straps_s[4])
    && common_clock_up_o == $past(straps_s[5]))
    else $error("common clock straps not latched");
endmodule : srm_top
